// ### hw/wdt_exec_map.vh
`ifndef WDT_EXEC_MAP_VH
`define WDT_EXEC_MAP_VH

// ------------------------------------------------------------
// Opcodes and masks
// ------------------------------------------------------------
`define OP_CLEAR_WATCHDOG  12'h004
`define OP_COMPLEMENT      12'h240
`define OP_DECREMENT       12'h0c0
`define OP_MASK_CLEAR      12'hfff
`define OP_MASK_FILE       12'hfc0

// ------------------------------------------------------------
// Instruction fields
// ------------------------------------------------------------
`define FLD_DEST           5
`define FLD_ADDR_HI        4
`define FLD_ADDR_LO        0

// ------------------------------------------------------------
// APB register map
// ------------------------------------------------------------
`define ADDR_INSTR         8'h00
`define ADDR_ACCUM         8'h04
`define ADDR_STATUS        8'h08
`define ADDR_CONTROL       8'h0c
`define ADDR_WATCHDOG      8'h10
`define ADDR_PRESCALER     8'h14
`define ADDR_FILE_BASE     8'h80

// ------------------------------------------------------------
// Status and control bits
// ------------------------------------------------------------
`define ST_ZERO            2
`define ST_POWERDOWN_N     3
`define ST_TIMEOUT_N       4
`define CTL_PSA            0
`define CTL_TICK           1

// ------------------------------------------------------------
// Reset values and counter constants
// ------------------------------------------------------------
`define RST_STATUS         8'h18
`define RST_BYTE           8'h00
`define ONE_BYTE           8'h01
`define RST_INSTR          12'h000
`define RST_WORD           32'h00000000
`define PRESCALE_WRAP      8'hff

// ------------------------------------------------------------
// File window address fields
// ------------------------------------------------------------
`define FILE_SEL_BIT       7
`define FILE_IDX_HI        6
`define FILE_IDX_LO        2

`endif

// ### hw/instr_alu.v
`timescale 1ns/1ps
`default_nettype none
`include "wdt_exec_map.vh"

module instr_alu #(
  parameter WIDTH = 8
) (
  input  wire [11:0]      instr,
  input  wire [WIDTH-1:0] operand,
  output wire             is_clear_watchdog,
  output wire             is_file_op,
  output wire [WIDTH-1:0] result,
  output wire             result_zero
);

  // ----------------------------------------------------------
  // Decode
  // ----------------------------------------------------------
  wire is_comp;
  wire is_dec;

  assign is_clear_watchdog = (instr == `OP_CLEAR_WATCHDOG);
  assign is_comp = ((instr & `OP_MASK_FILE) == `OP_COMPLEMENT);
  assign is_dec  = ((instr & `OP_MASK_FILE) == `OP_DECREMENT);
  assign is_file_op = is_comp | is_dec;

  // ----------------------------------------------------------
  // Result
  // ----------------------------------------------------------
  assign result = is_comp ? ~operand
                          : operand - {{(WIDTH-1){1'b0}}, 1'b1};
  assign result_zero = (result == {WIDTH{1'b0}});

endmodule // instr_alu
`default_nettype wire

// ### hw/wdt_exec.v
// The address map and the APB interface to the registers were decided locally.
`timescale 1ns/1ps
`default_nettype none
`include "wdt_exec_map.vh"

module wdt_exec #(
  parameter WIDTH = 8,
  parameter DEPTH = 32
) (
  input  wire        pclk,
  input  wire        presetn,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [7:0]  paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output wire        pready,
  output wire        pslverr
);

  // ----------------------------------------------------------
  // State
  // ----------------------------------------------------------
  reg  [WIDTH-1:0] file_mem [0:DEPTH-1];
  reg  [WIDTH-1:0] accum;
  reg  [7:0]       status;
  reg              psa_watchdog;
  reg  [7:0]       watchdog_counter;
  reg  [7:0]       prescaler;
  reg  [11:0]      last_instr;
  wire [WIDTH-1:0] result;
  wire             result_zero;
  wire             is_clear_watchdog;
  wire             is_file_op;
  wire [11:0]      instr;
  wire [4:0]       faddr;
  wire             dest_file;
  wire             wr;
  wire             rd;
  wire             instr_go;
  wire             tick;
  wire             file_sel;
  wire             known;

  assign wr = psel & penable & pwrite;
  assign rd = psel & ~pwrite;
  assign pready = 1'b1;
  assign file_sel = (paddr[`FILE_SEL_BIT] == 1'b1);
  assign known = file_sel | (paddr == `ADDR_INSTR) |
                 (paddr == `ADDR_ACCUM) | (paddr == `ADDR_STATUS) |
                 (paddr == `ADDR_CONTROL) | (paddr == `ADDR_WATCHDOG) |
                 (paddr == `ADDR_PRESCALER);
  assign pslverr = psel & penable & ~known;

  assign instr     = pwdata[11:0];
  assign faddr     = instr[`FLD_ADDR_HI:`FLD_ADDR_LO];
  assign dest_file = instr[`FLD_DEST];
  assign instr_go  = wr & (paddr == `ADDR_INSTR);
  assign tick = wr & (paddr == `ADDR_CONTROL) & pwdata[`CTL_TICK];

  // ----------------------------------------------------------
  // Decode and execute
  // ----------------------------------------------------------
  instr_alu #(
    .WIDTH (WIDTH)
  ) u_alu (
    .instr        (instr),
    .operand      (file_mem[faddr]),
    .is_clear_watchdog (is_clear_watchdog),
    .is_file_op   (is_file_op),
    .result       (result),
    .result_zero  (result_zero)
  );

  // ----------------------------------------------------------
  // Register file
  // ----------------------------------------------------------
  genvar gi;
  generate
    for (gi = 0; gi < DEPTH; gi = gi + 1) begin : g_file
      always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          file_mem[gi] <= `RST_BYTE;
        end else if (instr_go && is_file_op && dest_file &&
                     faddr == gi) begin
          file_mem[gi] <= result;
        end else if (wr && file_sel &&
                     paddr[`FILE_IDX_HI:`FILE_IDX_LO] == gi) begin
          file_mem[gi] <= pwdata[WIDTH-1:0];
        end
      end
    end
  endgenerate

  // ----------------------------------------------------------
  // Accumulator, status, watchdog
  // ----------------------------------------------------------
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      accum            <= `RST_BYTE;
      status           <= `RST_STATUS;
      psa_watchdog     <= 1'b0;
      watchdog_counter <= `RST_BYTE;
      prescaler        <= `RST_BYTE;
      last_instr       <= `RST_INSTR;
    end else begin
      if (instr_go) begin
        last_instr <= instr;
      end
      if (instr_go && is_file_op && !dest_file) begin
        accum <= result;
      end else if (wr && paddr == `ADDR_ACCUM) begin
        accum <= pwdata[WIDTH-1:0];
      end
      if (instr_go && is_file_op) begin
        status[`ST_ZERO] <= result_zero;
      end else if (instr_go && is_clear_watchdog) begin
        status[`ST_TIMEOUT_N]   <= 1'b1;
        status[`ST_POWERDOWN_N] <= 1'b1;
      end else if (wr && paddr == `ADDR_STATUS) begin
        status <= pwdata[7:0];
      end
      if (wr && paddr == `ADDR_CONTROL) begin
        psa_watchdog <= pwdata[`CTL_PSA];
      end
      if (instr_go && is_clear_watchdog) begin
        watchdog_counter <= `RST_BYTE;
        if (psa_watchdog) begin
          prescaler <= `RST_BYTE;
        end
      end else if (tick) begin
        prescaler <= prescaler + `ONE_BYTE;
        if (psa_watchdog && prescaler == `PRESCALE_WRAP) begin
          watchdog_counter <= watchdog_counter + `ONE_BYTE;
        end else if (!psa_watchdog) begin
          watchdog_counter <= watchdog_counter + `ONE_BYTE;
        end
      end
    end
  end

  // ----------------------------------------------------------
  // Read data
  // ----------------------------------------------------------
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= `RST_WORD;
    end else if (rd && !penable) begin
      prdata <= `RST_WORD;
      if (file_sel) begin
        prdata[WIDTH-1:0] <= file_mem[paddr[`FILE_IDX_HI:`FILE_IDX_LO]];
      end else begin
        case (paddr)
          `ADDR_INSTR:     prdata[11:0] <= last_instr;
          `ADDR_ACCUM:     prdata[WIDTH-1:0] <= accum;
          `ADDR_STATUS:    prdata[7:0] <= status;
          `ADDR_CONTROL:   prdata[0] <= psa_watchdog;
          `ADDR_WATCHDOG:  prdata[7:0] <= watchdog_counter;
          `ADDR_PRESCALER: prdata[7:0] <= prescaler;
          default:         prdata <= `RST_WORD;
        endcase
      end
    end
  end

endmodule // wdt_exec
`default_nettype wire

// ### verification/wdt_exec_props.sv
`timescale 1ns/1ps
`default_nettype none
// ------
// Checker
// ------
module wdt_exec_props (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr
);
  logic psa;
  wire  wr  = psel && penable && pwrite;
  wire  rs  = psel && !penable && !pwrite;
  wire  clr = wr && paddr == 8'h00 && pwdata[11:0] == 12'h004;
  always @(posedge pclk or negedge presetn)
    if (!presetn) psa <= 1'b0;
    else if (wr && paddr == 8'h0c) psa <= pwdata[0];
  property p_wd_zero;
    @(posedge pclk) disable iff (!presetn)
    clr ##2 (rs && paddr == 8'h10) |=> prdata == 32'h0;
  endproperty
  a_wd_zero: assert property (p_wd_zero) else $error("watchdog not zero");
  property p_ps_zero;
    @(posedge pclk) disable iff (!presetn)
    clr && psa ##2 (rs && paddr == 8'h14) |=> prdata == 32'h0;
  endproperty
  a_ps_zero: assert property (p_ps_zero) else $error("prescaler kept");
  property p_flags;
    @(posedge pclk) disable iff (!presetn)
    clr ##2 (rs && paddr == 8'h08) |=> prdata[4:3] == 2'b11;
  endproperty
  a_flags: assert property (p_flags) else $error("flags not set");
  property p_ready;
    @(posedge pclk) disable iff (!presetn) psel |-> pready;
  endproperty
  a_ready: assert property (p_ready) else $error("wait state seen");
  property p_err;
    @(posedge pclk) disable iff (!presetn)
    psel && penable && paddr[1:0] == 2'b00
      |-> pslverr == (paddr >= 8'h18 && paddr < 8'h80);
  endproperty
  a_err: assert property (p_err) else $error("bad error response");
  property p_err_idle;
    @(posedge pclk) disable iff (!presetn) pslverr |-> psel && penable;
  endproperty
  a_err_idle: assert property (p_err_idle) else $error("stray error");
  property p_hold;
    @(posedge pclk) disable iff (!presetn) !rs |=> $stable(prdata);
  endproperty
  a_hold: assert property (p_hold) else $error("read data moved");
endmodule // wdt_exec_props
bind wdt_exec wdt_exec_props chk (.pclk(pclk), .presetn(presetn),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));
`default_nettype wire

// ### verification/wdt_exec_test.sv
`timescale 1ns/1ps
`default_nettype none
// ------
// Bench
// ------
module wdt_exec_test;
  logic        pclk, presetn, psel, penable, pwrite;
  logic [7:0]  paddr;
  logic [31:0] pwdata, got;
  logic        got_err;
  wire  [31:0] prdata;
  wire         pready, pslverr;
  int          bad_count, checks_done;
  wdt_exec dut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr));
  initial begin
    pclk = 1'b0;
    forever #2 pclk = ~pclk;
  end
  task automatic complete_run;
    $display("Checks %0d, mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  task automatic xfer(input logic w, input logic [7:0] a,
                      input logic [31:0] d);
    int n = 0;
    @(posedge pclk);
    psel    <= 1'b1;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1 && n < 50) begin
      n++;
      @(posedge pclk);
    end
    got = prdata;
    got_err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    if (n == 50) begin
      bad_count++;
      $display("[FAIL] %0t no ready", $time);
      complete_run();
    end
  endtask
  task automatic err_is(input logic e);
    checks_done++;
    if (got_err !== e) begin
      bad_count++;
      $display("[FAIL] %0t error flag %b exp %b", $time, got_err, e);
    end
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    xfer(1'b0, a, 32'h0);
    checks_done++;
    if (got !== e) begin
      bad_count++;
      $display("[FAIL] %0t addr %h got %h exp %h", $time, a, got, e);
    end
  endtask
  initial begin
    presetn = 1'b0;
    psel    = 1'b0;
    penable = 1'b0;
    pwrite  = 1'b0;
    paddr   = 8'h00;
    pwdata  = 32'h0;
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    rd(8'h08, 32'h18);
    xfer(1'b1, 8'hfc, 32'h13);
    xfer(1'b1, 8'h00, 32'h25f);
    rd(8'h04, 32'hec);
    rd(8'hfc, 32'h13);
    rd(8'h08, 32'h18);
    xfer(1'b1, 8'h80, 32'hff);
    xfer(1'b1, 8'h00, 32'h260);
    rd(8'h80, 32'h00);
    rd(8'h04, 32'hec);
    rd(8'h08, 32'h1c);
    $display("Complement test done");
    xfer(1'b1, 8'h94, 32'h01);
    xfer(1'b1, 8'h00, 32'h0c5);
    rd(8'h04, 32'h00);
    rd(8'h94, 32'h01);
    rd(8'h08, 32'h1c);
    xfer(1'b1, 8'h00, 32'h0e5);
    xfer(1'b1, 8'h00, 32'h0e5);
    rd(8'h94, 32'hff);
    rd(8'h04, 32'h00);
    rd(8'h08, 32'h18);
    $display("Decrement test done");
    xfer(1'b1, 8'h08, 32'h04);
    xfer(1'b1, 8'h0c, 32'h02);
    xfer(1'b1, 8'h0c, 32'h02);
    rd(8'h10, 32'h02);
    xfer(1'b1, 8'h00, 32'h004);
    rd(8'h10, 32'h00);
    rd(8'h14, 32'h02);
    rd(8'h08, 32'h1c);
    xfer(1'b1, 8'h0c, 32'h01);
    xfer(1'b1, 8'h0c, 32'h03);
    rd(8'h14, 32'h03);
    xfer(1'b1, 8'h00, 32'h004);
    rd(8'h14, 32'h00);
    xfer(1'b1, 8'h00, 32'h004);
    rd(8'h08, 32'h1c);
    $display("Watchdog test done");
    rd(8'h0c, 32'h01);
    xfer(1'b1, 8'h40, 32'hff);
    err_is(1'b1);
    rd(8'h40, 32'h00);
    err_is(1'b1);
    $display("Unmapped test done");
    xfer(1'b1, 8'h00, 32'h040);
    err_is(1'b0);
    rd(8'h00, 32'h040);
    rd(8'h08, 32'h1c);
    $display("Other opcode test done");
    @(posedge pclk);
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    rd(8'h08, 32'h18);
    rd(8'hfc, 32'h00);
    rd(8'h0c, 32'h00);
    $display("Reset test done");
    complete_run();
  end
endmodule // wdt_exec_test
`default_nettype wire
